/* hdl/pfod_pkg.sv */
package pfod_pkg;
  // ----------------------------------------
  // Register map (word index on addr)
  // ----------------------------------------
  localparam int unsigned ADDR_W = 3;
  localparam logic [2:0] ADDR_FBC = 3'h0;
  localparam logic [2:0] ADDR_OVD = 3'h1;
  localparam logic [2:0] ADDR_DC1 = 3'h2;
  localparam logic [2:0] ADDR_DC2 = 3'h3;
  localparam logic [2:0] ADDR_DC3 = 3'h4;
  localparam logic [2:0] ADDR_DC4 = 3'h5;
  localparam logic [2:0] ADDR_CTL = 3'h6;
  localparam logic [2:0] ADDR_FST = 3'h7;
  // ----------------------------------------
  // Widths, fields, reset values
  // ----------------------------------------
  localparam int unsigned DW = 16;
  localparam int unsigned NPAIR = 4;
  localparam int unsigned NPIN = 8;
  localparam int unsigned CTL_W = 3;
  localparam logic [15:0] FBC_WMASK = 16'hFF8F;
  localparam logic [15:0] FBC_RST = 16'h0000;
  localparam logic [15:0] OVD_RST = 16'hFF00;
  localparam logic [15:0] DC_RST = 16'h0000;
  localparam logic [2:0] CTL_RST = 3'h0;
  localparam int unsigned FBC_MODE_BIT = 7;
  localparam int unsigned FBC_LVL_LSB = 8;
  localparam int unsigned OVD_SEL_LSB = 8;
  localparam int unsigned CTL_UPD_DIS = 0;
  localparam int unsigned CTL_OVR_SYNC = 1;
  localparam int unsigned CTL_IMM_UPD = 2;
  localparam int unsigned FST_CLR_BIT = 0;
  localparam int unsigned FST_RAW_BIT = 1;
endpackage

/* hdl/pfod_fault_b.sv */
module pfod_fault_b (
  input wire logic mclk,
  input wire logic rst,
  input wire logic fault_b,
  input wire logic second_fault_mode_select,
  input wire logic period_start,
  input wire logic clear,
  output logic ovr_active,
  output logic latched
);
  typedef struct packed {
    logic latch;
    logic cbc;
  } pfod_fb_state_t;

  pfod_fb_state_t st_q;
  pfod_fb_state_t st_d;

  always_comb begin
    st_d = st_q;
    if (!second_fault_mode_select) begin
      if (fault_b) begin
        st_d.latch = 1'b1;
      end else if (clear) begin
        st_d.latch = 1'b0;
      end
    end
    if (second_fault_mode_select) begin
      if (fault_b) begin
        st_d.cbc = 1'b1;
      end else if (period_start) begin
        st_d.cbc = 1'b0;
      end
    end else begin
      st_d.cbc = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign ovr_active = second_fault_mode_select ? (fault_b | st_q.cbc) : (fault_b | st_q.latch);
  assign latched = st_q.latch;
endmodule

/* hdl/pfod_duty_bank.sv */
module pfod_duty_bank (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wr,
  input wire logic [1:0] sel,
  input wire logic [15:0] wdata,
  input wire logic immediate_duty_update,
  input wire logic buffer_update_disable,
  input wire logic period_start,
  output logic [3:0][15:0] duty_buf,
  output logic [3:0][15:0] duty_act
);
  typedef struct packed {
    logic [3:0][15:0] buf_v;
    logic [3:0][15:0] act;
  } pfod_db_state_t;

  pfod_db_state_t st_q;
  pfod_db_state_t st_d;

  always_comb begin
    st_d = st_q;
    for (int i = 0; i < pfod_pkg::NPAIR; i++) begin
      if (wr && sel == 2'(i)) begin
        st_d.buf_v[i] = wdata;
      end
      if (!buffer_update_disable) begin
        if (immediate_duty_update) begin
          st_d.act[i] = st_d.buf_v[i];
        end else if (period_start) begin
          st_d.act[i] = st_q.buf_v[i];
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= {(2 * pfod_pkg::NPAIR){pfod_pkg::DC_RST}};
    end else begin
      st_q <= st_d;
    end
  end

  assign duty_buf = st_q.buf_v;
  assign duty_act = st_q.act;
endmodule

/* hdl/pfod_top.sv */
module pfod_top (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [2:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic period_start,
  input wire logic fault_b,
  input wire logic [3:0] fault_a_force,
  input wire logic [7:0] fault_a_level,
  input wire logic [7:0] gen_out,
  output logic [7:0] pwm_out,
  output logic [15:0] duty_value_gen1,
  output logic [15:0] duty_value_gen2,
  output logic [15:0] duty_value_gen3,
  output logic [15:0] duty_value_gen4
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] fbc;
    logic [15:0] ovd_buf;
    logic [15:0] ovd_act;
    logic [2:0] ctl;
    logic [15:0] rdata;
    logic [7:0] pins;
  } pfod_state_t;

  pfod_state_t st_q;
  pfod_state_t st_d;

  logic [3:0][15:0] duty_buf;
  logic [3:0][15:0] duty_act;
  logic ovr_b;
  logic latched_b;
  logic clr_b;
  logic [7:0] second_fault_override_levels;
  logic second_fault_mode_select;
  logic [3:0] second_fault_enables;
  logic [7:0] pin_generator_select;
  logic [7:0] pin_manual_level;
  logic override_sync_select;
  logic immediate_duty_update;
  logic buffer_update_disable;
  logic duty_wr;
  logic [2:0] duty_idx;

  assign second_fault_override_levels = st_q.fbc[pfod_pkg::FBC_LVL_LSB +: pfod_pkg::NPIN];
  assign second_fault_mode_select = st_q.fbc[pfod_pkg::FBC_MODE_BIT];
  assign second_fault_enables = st_q.fbc[pfod_pkg::NPAIR-1:0];
  assign pin_generator_select = st_q.ovd_act[pfod_pkg::OVD_SEL_LSB +: pfod_pkg::NPIN];
  assign pin_manual_level = st_q.ovd_act[pfod_pkg::NPIN-1:0];
  assign override_sync_select = st_q.ctl[pfod_pkg::CTL_OVR_SYNC];
  assign immediate_duty_update = st_q.ctl[pfod_pkg::CTL_IMM_UPD];
  assign buffer_update_disable = st_q.ctl[pfod_pkg::CTL_UPD_DIS];
  assign duty_wr = wr && addr >= pfod_pkg::ADDR_DC1 && addr <= pfod_pkg::ADDR_DC4;
  assign duty_idx = addr - pfod_pkg::ADDR_DC1;
  assign clr_b = wr && addr == pfod_pkg::ADDR_FST && wdata[pfod_pkg::FST_CLR_BIT];

  // ----------------------------------------
  // Fault B tracking and duty registers
  // ----------------------------------------
  pfod_fault_b u_fault_b (
    .mclk(mclk),
    .rst(rst),
    .fault_b(fault_b),
    .second_fault_mode_select(second_fault_mode_select),
    .period_start(period_start),
    .clear(clr_b),
    .ovr_active(ovr_b),
    .latched(latched_b)
  );

  pfod_duty_bank u_duty (
    .mclk(mclk),
    .rst(rst),
    .wr(duty_wr),
    .sel(duty_idx[1:0]),
    .wdata(wdata),
    .immediate_duty_update(immediate_duty_update),
    .buffer_update_disable(buffer_update_disable),
    .period_start(period_start),
    .duty_buf(duty_buf),
    .duty_act(duty_act)
  );

  // ----------------------------------------
  // Register writes, reads and pin mux
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    if (wr) begin
      unique case (addr)
        pfod_pkg::ADDR_FBC: st_d.fbc = wdata & pfod_pkg::FBC_WMASK;
        pfod_pkg::ADDR_OVD: st_d.ovd_buf = wdata;
        pfod_pkg::ADDR_CTL: st_d.ctl = wdata[pfod_pkg::CTL_W-1:0];
        default: st_d.ctl = st_q.ctl;
      endcase
    end
    if (!override_sync_select || period_start) begin
      st_d.ovd_act = st_d.ovd_buf;
    end
    if (rd) begin
      unique case (addr)
        pfod_pkg::ADDR_FBC: st_d.rdata = st_q.fbc;
        pfod_pkg::ADDR_OVD: st_d.rdata = st_q.ovd_buf;
        pfod_pkg::ADDR_DC1: st_d.rdata = duty_buf[0];
        pfod_pkg::ADDR_DC2: st_d.rdata = duty_buf[1];
        pfod_pkg::ADDR_DC3: st_d.rdata = duty_buf[2];
        pfod_pkg::ADDR_DC4: st_d.rdata = duty_buf[3];
        pfod_pkg::ADDR_CTL: st_d.rdata = 16'(st_q.ctl);
        pfod_pkg::ADDR_FST: st_d.rdata = 16'({fault_b, latched_b} );
      endcase
    end
    for (int p = 0; p < pfod_pkg::NPIN; p++) begin
      if (pin_generator_select[p]) begin
        st_d.pins[p] = gen_out[p];
      end else begin
        st_d.pins[p] = pin_manual_level[p];
      end
      if (second_fault_enables[p/2] && ovr_b) begin
        st_d.pins[p] = second_fault_override_levels[p];
      end
      if (fault_a_force[p/2]) begin
        st_d.pins[p] = fault_a_level[p];
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q.fbc <= pfod_pkg::FBC_RST;
      st_q.ovd_buf <= pfod_pkg::OVD_RST;
      st_q.ovd_act <= pfod_pkg::OVD_RST;
      st_q.ctl <= pfod_pkg::CTL_RST;
      st_q.rdata <= '0;
      st_q.pins <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata = st_q.rdata;
  assign pwm_out = st_q.pins;
  assign duty_value_gen1 = duty_act[0];
  assign duty_value_gen2 = duty_act[1];
  assign duty_value_gen3 = duty_act[2];
  assign duty_value_gen4 = duty_act[3];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  chk_unimpl_read_zero: assert property (
    rd && addr == pfod_pkg::ADDR_FBC |=> rdata[6:4] == 3'h0)
    else $error("Unimplemented fault B bits read nonzero");

  chk_manual_pin_level: assert property (
    !pin_generator_select[0] && !fault_a_force[0] && !(second_fault_enables[0] && ovr_b)
    |=> pwm_out[0] == $past(pin_manual_level[0]))
    else $error("Pin 0 ignores manual level");

  chk_gen_pin_follow: assert property (
    pin_generator_select[1] && !fault_a_force[0] && !(second_fault_enables[0] && ovr_b)
    |=> pwm_out[1] == $past(gen_out[1]))
    else $error("Pin 1 ignores generator");

  chk_fault_a_first: assert property (
    fault_a_force[1] |=> pwm_out[3:2] == $past(fault_a_level[3:2]))
    else $error("Fault A did not win on pair 2");

  chk_fault_b_level: assert property (
    fault_b && second_fault_enables[1] && !fault_a_force[1]
    |=> pwm_out[3:2] == $past(second_fault_override_levels[3:2]))
    else $error("Fault B level not applied on pair 2");

  chk_latch_holds: assert property (
    !second_fault_mode_select && fault_b ##1 (!clr_b && !second_fault_mode_select)[*3] |-> ovr_b)
    else $error("Latched fault released without clear");

  chk_cbc_release: assert property (
    second_fault_mode_select && !fault_b && period_start ##1
    (second_fault_mode_select && !fault_b) |-> !ovr_b)
    else $error("Cycle fault not released at period start");

  chk_override_defer: assert property (
    override_sync_select && !period_start && !wr |=> $stable(st_q.ovd_act))
    else $error("Override changed off the boundary");

  chk_duty_blocked: assert property (
    buffer_update_disable && !(wr && addr == pfod_pkg::ADDR_CTL) |=> $stable(duty_act))
    else $error("Duty transfer while disabled");

  // ----------------------------------------
  // Reset, fault A, fault B, pin, override and duty checks
  // ----------------------------------------
  chk_reset_values: assert property (
    disable iff (1'b0)
    rst |=> st_q.ovd_act == pfod_pkg::OVD_RST && st_q.fbc == pfod_pkg::FBC_RST
    && duty_act == {pfod_pkg::NPAIR{pfod_pkg::DC_RST}})
    else $error("Reset values not applied");

  chk_unimpl_zero: assert property (
    st_q.fbc[6:4] == 3'h0)
    else $error("Unimplemented fault B bits hold ones");

  chk_fault_b_pair1: assert property (
    ovr_b && second_fault_enables[0] && !fault_a_force[0]
    |=> pwm_out[1:0] == $past(second_fault_override_levels[1:0]))
    else $error("Fault B level not applied on pair 1");

  chk_latch_sets: assert property (
    !second_fault_mode_select && fault_b
    |=> latched_b)
    else $error("Fault B event not latched");

  chk_cbc_follows: assert property (
    second_fault_mode_select && fault_b && !(wr && addr == pfod_pkg::ADDR_FBC)
    |=> ovr_b)
    else $error("Cycle fault not held after event");

  chk_cbc_holds: assert property (
    second_fault_mode_select && ovr_b && !period_start && !(wr && addr == pfod_pkg::ADDR_FBC)
    |=> ovr_b)
    else $error("Cycle fault released before period start");

  chk_latch_clears: assert property (
    !second_fault_mode_select && !fault_b && clr_b
    |=> !latched_b)
    else $error("Latch not cleared by software");

  chk_set_beats_clear: assert property (
    !second_fault_mode_select && fault_b && clr_b
    |=> latched_b)
    else $error("Clear won over an active fault");

  chk_status_latch: assert property (
    rd && addr == pfod_pkg::ADDR_FST
    |=> rdata[pfod_pkg::FST_CLR_BIT] == $past(latched_b))
    else $error("Status does not show the latch");

  chk_pair_uncontrolled: assert property (
    ovr_b && !second_fault_enables[3] && !fault_a_force[3] && pin_generator_select[7]
    |=> pwm_out[7] == $past(gen_out[7]))
    else $error("Disabled pair 4 touched by fault B");

  chk_manual_high_pin: assert property (
    !pin_generator_select[6] && !fault_a_force[3] && !(second_fault_enables[3] && ovr_b)
    |=> pwm_out[6] == $past(pin_manual_level[6]))
    else $error("Pin 6 ignores manual level");

  chk_fault_a_pair1: assert property (
    fault_a_force[0]
    |=> pwm_out[1:0] == $past(fault_a_level[1:0]))
    else $error("Fault A did not win on pair 1");

  chk_override_free: assert property (
    !override_sync_select
    |=> st_q.ovd_act == st_q.ovd_buf)
    else $error("Override not applied on next cycle");

  chk_override_boundary: assert property (
    period_start
    |=> st_q.ovd_act == st_q.ovd_buf)
    else $error("Override not applied at boundary");

  chk_immediate_duty: assert property (
    immediate_duty_update && !buffer_update_disable
    |=> duty_act == duty_buf)
    else $error("Immediate duty update missed");

  chk_period_transfer: assert property (
    period_start && !immediate_duty_update && !buffer_update_disable
    |=> duty_act == $past(duty_buf))
    else $error("Duty not moved at period start");

  chk_duty_held: assert property (
    !immediate_duty_update && !period_start
    |=> $stable(duty_act))
    else $error("Duty moved between boundaries");

  chk_duty_read: assert property (
    rd && addr == pfod_pkg::ADDR_DC1
    |=> rdata == $past(duty_buf[0]))
    else $error("Duty one read back wrong");
endmodule

/* verif/pfod_stage_model.sv */
module pfod_stage_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic trip_b,
  input wire logic [3:0] trip_a,
  input wire logic [7:0] trip_a_level,
  output logic fault_b,
  output logic [3:0] fault_a_force,
  output logic [7:0] fault_a_level
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Fault sensors, one cycle of sense delay
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fault_b <= 1'b0;
      fault_a_force <= 4'h0;
      fault_a_level <= 8'h00;
    end else begin
      fault_b <= trip_b;
      fault_a_force <= trip_a;
      fault_a_level <= trip_a_level;
    end
  end
endmodule

/* verif/test_pwm_fault_override_duty.sv */
module test_pwm_fault_override_duty;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic period_start = 1'b0;
  logic trip_b = 1'b0;
  logic [3:0] trip_a = 4'h0;
  logic [7:0] trip_a_level = 8'h00;
  logic [7:0] gen_out = 8'h3c;
  logic [15:0] rdata;
  logic fault_b;
  logic [3:0] fault_a_force;
  logic [7:0] fault_a_level;
  logic [7:0] pwm_out;
  wire logic [3:0][15:0] dv;
  int err_count = 0;
  int n_checks = 0;
  always #50 mclk = ~mclk;
  pfod_top i_dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .period_start(period_start), .fault_b(fault_b), .fault_a_force(fault_a_force),
    .fault_a_level(fault_a_level), .gen_out(gen_out), .pwm_out(pwm_out), .duty_value_gen1(dv[0]),
    .duty_value_gen2(dv[1]), .duty_value_gen3(dv[2]), .duty_value_gen4(dv[3]));
  pfod_stage_model i_stage (.mclk(mclk), .rst(rst), .trip_b(trip_b), .trip_a(trip_a),
    .trip_a_level(trip_a_level), .fault_b(fault_b), .fault_a_force(fault_a_force),
    .fault_a_level(fault_a_level));
  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [15:0] exp);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk("rdata", exp, rdata);
  endtask
  task automatic settle();
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task automatic pins(input logic [7:0] exp);
    settle();
    chk("pwm_out", {8'h00, exp}, {8'h00, pwm_out});
  endtask
  task automatic pulse_period();
    @(posedge mclk);
    period_start <= 1'b1;
    @(posedge mclk);
    period_start <= 1'b0;
    settle();
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge mclk);
    err_count++;
    test_done();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    rd_chk(pfod_pkg::ADDR_FBC, 16'h0000);
    rd_chk(pfod_pkg::ADDR_OVD, 16'hff00);
    for (int i = 0; i < 4; i++) rd_chk(pfod_pkg::ADDR_DC1 + 3'(i), 16'h0000);
    pins(8'h3c);
    wr_reg(pfod_pkg::ADDR_FBC, 16'hffff);
    rd_chk(pfod_pkg::ADDR_FBC, 16'hff8f);
    $display("test reset and reserved done");
    wr_reg(pfod_pkg::ADDR_CTL, 16'h0004);
    rd_chk(pfod_pkg::ADDR_CTL, 16'h0004);
    for (int i = 0; i < 4; i++) wr_reg(pfod_pkg::ADDR_DC1 + 3'(i), 16'h8001 + 16'(i));
    settle();
    for (int i = 0; i < 4; i++) begin
      rd_chk(pfod_pkg::ADDR_DC1 + 3'(i), 16'h8001 + 16'(i));
      chk("duty_act", 16'h8001 + 16'(i), dv[i]);
    end
    wr_reg(pfod_pkg::ADDR_CTL, 16'h0001);
    wr_reg(pfod_pkg::ADDR_DC1, 16'h0bad);
    pulse_period();
    chk("duty_act", 16'h8001, dv[0]);
    wr_reg(pfod_pkg::ADDR_CTL, 16'h0000);
    settle();
    chk("duty_act", 16'h8001, dv[0]);
    pulse_period();
    chk("duty_act", 16'h0bad, dv[0]);
    $display("test duty done");
    wr_reg(pfod_pkg::ADDR_OVD, 16'h0fa5);
    pins(8'hac);
    wr_reg(pfod_pkg::ADDR_CTL, 16'h0002);
    wr_reg(pfod_pkg::ADDR_OVD, 16'h00ff);
    pins(8'hac);
    pulse_period();
    chk("pwm_out", 16'h00ff, {8'h00, pwm_out});
    wr_reg(pfod_pkg::ADDR_CTL, 16'h0000);
    wr_reg(pfod_pkg::ADDR_OVD, 16'hff00);
    pins(8'h3c);
    $display("test override done");
    wr_reg(pfod_pkg::ADDR_FBC, 16'h5a03);
    @(posedge mclk);
    trip_b <= 1'b1;
    pins(8'h3a);
    @(posedge mclk);
    trip_a <= 4'h3;
    trip_a_level <= 8'h09;
    pins(8'h39);
    rd_chk(pfod_pkg::ADDR_FST, 16'h0003);
    wr_reg(pfod_pkg::ADDR_FST, 16'h0001);
    pins(8'h39);
    @(posedge mclk);
    trip_a <= 4'h0;
    trip_b <= 1'b0;
    pins(8'h3a);
    rd_chk(pfod_pkg::ADDR_FST, 16'h0001);
    wr_reg(pfod_pkg::ADDR_FST, 16'h0001);
    pins(8'h3c);
    rd_chk(pfod_pkg::ADDR_FST, 16'h0000);
    wr_reg(pfod_pkg::ADDR_FBC, 16'h5a83);
    @(posedge mclk);
    trip_b <= 1'b1;
    pins(8'h3a);
    @(posedge mclk);
    trip_b <= 1'b0;
    pins(8'h3a);
    pulse_period();
    chk("pwm_out", 16'h003c, {8'h00, pwm_out});
    $display("test fault b done");
    test_done();
  end
endmodule
